// ==== logic/fifo_ports.sv ====
// How it works
// - Mode pin caught during master reset
// - Standard mode uses empty and full flags
// - Fall-through mode uses output/input ready flags
// - Standard read loads output unless empty
// - Read select gates port, tri-states output
// - Standard write stores word unless full
// - Write select low needed to store
// - Fall-through read loads while output ready
// - First word falls through third edge
// - Fall-through write stores while space available
// - Mark records current read location
// - Replay request starts setup, empty low
// - Replay reads restart at marked location
// - Write pointer never passes the mark
// - Master reset clears pointers and output register
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fifo_ports
	import fifo_ports_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Device control
	input  wire logic              master_reset_n,
	input  wire logic              mode_select_std,
	// Write port
	input  wire write_port_t       wr,
	// Read port
	input  wire read_port_t        rd,
	output logic      [DATA_W-1:0] q,
	output logic                   q_oe,
	// Flags
	output logic                   empty_flag_n,
	output logic                   output_ready_n,
	output logic                   full_flag_n,
	output logic                   input_space_avail_n,
	// Register bus
	input  wire axil_req_t         axi_req,
	output axil_rsp_t              axi_rsp
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                   mode_std;
		logic [ADDR_W:0]        wr_ptr;
		logic [ADDR_W:0]        rd_ptr;
		logic [ADDR_W:0]        mark_ptr;
		logic                   mark_valid;
		logic                   setup;
		logic [1:0]             setup_cnt;
		logic [FALL_STAGES-1:0] avail_pipe;
		logic [DATA_W-1:0]      q;
		logic                   q_oe;
		logic                   empty_flag_n;
		logic                   output_ready_n;
		logic                   full_flag_n;
		logic                   input_space_avail_n;
		logic                   replay_dis;
		logic                   write_hold;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} state_t;

	localparam state_t STATE_RST = '{
		mode_std:            1'b1,
		wr_ptr:              PTR_ZERO,
		rd_ptr:              PTR_ZERO,
		mark_ptr:            PTR_ZERO,
		mark_valid:          1'b0,
		setup:               1'b0,
		setup_cnt:           2'h0,
		avail_pipe:          '0,
		q:                   '0,
		q_oe:                1'b0,
		empty_flag_n:        1'b0,
		output_ready_n:      1'b1,
		full_flag_n:         1'b1,
		input_space_avail_n: 1'b1,
		replay_dis:          1'b0,
		write_hold:          1'b0,
		awready:             1'b0,
		wready:              1'b0,
		bvalid:              1'b0,
		bresp:               RESP_OKAY,
		arready:             1'b0,
		rvalid:              1'b0,
		rdata:               32'h0000_0000,
		rresp:               RESP_OKAY
	};

	state_t            s_reg;
	state_t            s_next;
	logic              wr_go;
	logic              std_read;
	logic              fwft_take;
	logic              fall_ready;
	logic              fwft_fill;
	logic              rd_go;
	logic              replay_go;
	logic [ADDR_W:0]   fill_cnt;
	logic [ADDR_W:0]   fill_next;
	logic [ADDR_W:0]   hold_next;
	logic              no_space;
	logic [DATA_W-1:0] ram_rdata;
	reg_sel_t          wsel;
	reg_sel_t          rsel;

	// ****************************************
	// Register decode
	// ****************************************
	function automatic reg_sel_t reg_decode(input logic [AXI_AW-1:0] addr);
		if (addr == CTRL_OFF) begin
			return REG_CTRL;
		end
		if (addr == STATUS_OFF) begin
			return REG_STATUS;
		end
		return REG_NONE;
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	fifo_store u_store (
		.aclk  (aclk),
		.we    (wr_go),
		.waddr (s_reg.wr_ptr[ADDR_W-1:0]),
		.wdata (wr.d),
		.raddr (s_reg.rd_ptr[ADDR_W-1:0]),
		.rdata (ram_rdata)
	);

	// ****************************************
	// Port qualification
	// ****************************************
	always_comb begin
		fill_cnt = s_reg.wr_ptr - s_reg.rd_ptr;
		// Writes wait on the flag of the active mode
		wr_go = !wr.wen_n && !wr.write_port_select_n && master_reset_n
			&& (s_reg.mode_std ? s_reg.full_flag_n
			: !s_reg.input_space_avail_n);
		replay_go = !rd.replay_request_n && s_reg.mark_valid && !s_reg.setup
			&& !s_reg.replay_dis && master_reset_n;
		std_read = s_reg.mode_std && !rd.ren_n && !rd.read_port_select_n
			&& s_reg.empty_flag_n && !s_reg.setup && !replay_go;
		fall_ready = s_reg.avail_pipe[FALL_STAGES-1] && (fill_cnt != PTR_ZERO);
		fwft_take = !s_reg.mode_std && !rd.ren_n && !rd.read_port_select_n
			&& !s_reg.output_ready_n && !s_reg.setup && !replay_go;
		// Empty output register refills by itself once the word has settled
		fwft_fill = !s_reg.mode_std && !s_reg.setup && !replay_go && fall_ready
			&& (s_reg.output_ready_n || fwft_take);
		rd_go = (std_read || fwft_fill) && master_reset_n;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		fill_next = PTR_ZERO;
		hold_next = PTR_ZERO;
		no_space = 1'b0;
		wsel = reg_decode(axi_req.awaddr);
		rsel = reg_decode(axi_req.araddr);

		// Write side
		if (wr_go) begin
			s_next.wr_ptr = s_reg.wr_ptr + PTR_ONE;
		end

		// Read side
		if (rd_go) begin
			s_next.q = ram_rdata;
			s_next.rd_ptr = s_reg.rd_ptr + PTR_ONE;
			s_next.output_ready_n = s_reg.mode_std;
		end else if (fwft_take) begin
			s_next.output_ready_n = 1'b1;
		end
		s_next.avail_pipe = {s_reg.avail_pipe[FALL_STAGES-2:0], fill_cnt != PTR_ZERO};
		s_next.q_oe = !rd.read_port_select_n;

		// Mark holds while the mark input stays high
		if (!rd.mark) begin
			s_next.mark_valid = 1'b0;
		end else if (!s_reg.mark_valid) begin
			s_next.mark_valid = 1'b1;
			s_next.mark_ptr = s_reg.rd_ptr;
		end

		// Replay setup
		if (replay_go) begin
			s_next.setup = 1'b1;
			s_next.setup_cnt = RT_SETUP_LAST;
			s_next.rd_ptr = s_reg.mark_ptr;
			s_next.output_ready_n = 1'b1;
			s_next.avail_pipe = '0;
		end else if (s_reg.setup) begin
			if (s_reg.setup_cnt == 2'h0) begin
				s_next.setup = 1'b0;
			end else begin
				s_next.setup_cnt = s_reg.setup_cnt - 2'h1;
			end
		end

		// Flags follow the updated pointers
		fill_next = s_next.wr_ptr - s_next.rd_ptr;
		hold_next = s_next.wr_ptr - (s_next.mark_valid ? s_next.mark_ptr : s_next.rd_ptr);
		no_space = (hold_next == DEPTH) || s_next.write_hold;
		if (s_reg.mode_std) begin
			s_next.empty_flag_n = (fill_next != PTR_ZERO) && !s_next.setup;
			s_next.full_flag_n = !no_space;
			s_next.output_ready_n = 1'b1;
			s_next.input_space_avail_n = 1'b1;
		end else begin
			s_next.empty_flag_n = !s_next.setup;
			s_next.full_flag_n = 1'b1;
			s_next.input_space_avail_n = no_space;
		end

		// Master reset clears the FIFO and catches the mode pin
		if (!master_reset_n) begin
			s_next.mode_std = mode_select_std;
			s_next.wr_ptr = PTR_ZERO;
			s_next.rd_ptr = PTR_ZERO;
			s_next.mark_ptr = PTR_ZERO;
			s_next.mark_valid = 1'b0;
			s_next.setup = 1'b0;
			s_next.setup_cnt = 2'h0;
			s_next.avail_pipe = '0;
			s_next.q = '0;
			s_next.empty_flag_n = !mode_select_std;
			s_next.output_ready_n = 1'b1;
			s_next.full_flag_n = 1'b1;
			s_next.input_space_avail_n = mode_select_std;
		end

		// Register bus write channel
		s_next.awready = 1'b0;
		s_next.wready = 1'b0;
		if (s_reg.awready) begin
			s_next.bvalid = 1'b1;
			s_next.bresp = (wsel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
			if (wsel == REG_CTRL && axi_req.wstrb[0]) begin
				s_next.replay_dis = axi_req.wdata[CTRL_RPL_DIS];
				s_next.write_hold = axi_req.wdata[CTRL_WR_HOLD];
			end
		end else if (s_reg.bvalid) begin
			if (axi_req.bready) begin
				s_next.bvalid = 1'b0;
			end
		end else if (axi_req.awvalid && axi_req.wvalid) begin
			s_next.awready = 1'b1;
			s_next.wready = 1'b1;
		end

		// Register bus read channel
		s_next.arready = 1'b0;
		if (s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = 32'h0000_0000;
			s_next.rresp = RESP_OKAY;
			unique case (rsel)
				REG_CTRL: begin
					s_next.rdata[CTRL_RPL_DIS] = s_reg.replay_dis;
					s_next.rdata[CTRL_WR_HOLD] = s_reg.write_hold;
				end
				REG_STATUS: begin
					s_next.rdata[ST_MODE_STD] = s_reg.mode_std;
					s_next.rdata[ST_MARK] = s_reg.mark_valid;
					s_next.rdata[ST_SETUP] = s_reg.setup;
					s_next.rdata[ST_FILL_LSB +: PTR_W] = fill_cnt;
				end
				REG_NONE: begin
					s_next.rresp = RESP_DECERR;
				end
			endcase
		end else if (s_reg.rvalid) begin
			if (axi_req.rready) begin
				s_next.rvalid = 1'b0;
			end
		end else if (axi_req.arvalid) begin
			s_next.arready = 1'b1;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign q                   = s_reg.q;
	assign q_oe                = s_reg.q_oe;
	assign empty_flag_n        = s_reg.empty_flag_n;
	assign output_ready_n      = s_reg.output_ready_n;
	assign full_flag_n         = s_reg.full_flag_n;
	assign input_space_avail_n = s_reg.input_space_avail_n;
	assign axi_rsp.awready     = s_reg.awready;
	assign axi_rsp.wready      = s_reg.wready;
	assign axi_rsp.bvalid      = s_reg.bvalid;
	assign axi_rsp.bresp       = s_reg.bresp;
	assign axi_rsp.arready     = s_reg.arready;
	assign axi_rsp.rvalid      = s_reg.rvalid;
	assign axi_rsp.rdata       = s_reg.rdata;
	assign axi_rsp.rresp       = s_reg.rresp;

endmodule

`default_nettype wire

// ==== logic/fifo_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module fifo_store
	import fifo_ports_pkg::*;
(
	// Clock
	input  wire logic              aclk,
	// Write side
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	// Read side
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];

endmodule

`default_nettype wire

// ==== pkg/fifo_ports_pkg.sv ====
package fifo_ports_pkg;

	// ****************************************
	// Storage geometry
	// ****************************************
	localparam int              DATA_W   = 36;
	localparam int              ADDR_W   = 6;
	localparam int              PTR_W    = ADDR_W + 1;
	localparam logic [ADDR_W:0] DEPTH    = 7'h40;
	localparam logic [ADDR_W:0] PTR_ZERO = 7'h00;
	localparam logic [ADDR_W:0] PTR_ONE  = 7'h01;

	// ****************************************
	// Sequencing counts
	// ****************************************
	localparam logic [1:0] RT_SETUP_LAST = 2'h1;
	localparam int         FALL_STAGES   = 2;

	// ****************************************
	// Register bus map
	// ****************************************
	localparam int         AXI_AW        = 8;
	localparam logic [7:0] CTRL_OFF      = 8'h00;
	localparam logic [7:0] STATUS_OFF    = 8'h04;
	localparam int         CTRL_RPL_DIS  = 0;
	localparam int         CTRL_WR_HOLD  = 1;
	localparam int         ST_MODE_STD   = 0;
	localparam int         ST_MARK       = 1;
	localparam int         ST_SETUP      = 2;
	localparam int         ST_FILL_LSB   = 8;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_DECERR   = 2'h3;

	typedef enum logic [1:0] {
		REG_CTRL,
		REG_STATUS,
		REG_NONE
	} reg_sel_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic              wen_n;
		logic              write_port_select_n;
		logic [DATA_W-1:0] d;
	} write_port_t;

	typedef struct packed {
		logic ren_n;
		logic read_port_select_n;
		logic mark;
		logic replay_request_n;
	} read_port_t;

	typedef struct packed {
		logic              awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [AXI_AW-1:0] araddr;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

endpackage

// ==== verif/fifo_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fifo_ctl_model
	import fifo_ports_pkg::*;
(
	// Clock
	input  wire logic       aclk,
	// Controls
	output var write_port_t wr,
	output var read_port_t  rd,
	output var logic        master_reset_n,
	output var logic        mode_select_std
);
	initial begin
		wr = {1'b1, 1'b1, 36'h0};
		rd = 4'hD;
		master_reset_n = 1'b0;
		mode_select_std = 1'b1;
	end

	// ********
	// Strobes
	// ********
	task automatic mrst(input logic std);
		mode_select_std <= std;
		master_reset_n <= 1'b0;
		rd <= 4'hD;
		repeat (10) @(posedge aclk);
		master_reset_n <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic put(input logic [DATA_W-1:0] d, input logic sel_n);
		wr <= {1'b0, sel_n, d};
		@(posedge aclk);
		wr <= {1'b1, 1'b1, ~d};
		@(posedge aclk);
	endtask

	task automatic get();
		rd.ren_n <= 1'b0;
		rd.read_port_select_n <= 1'b0;
		@(posedge aclk);
		rd.ren_n <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic strobe(input logic mk, input logic sel_n);
		rd.mark <= mk;
		rd.read_port_select_n <= sel_n;
		@(posedge aclk);
	endtask

	// Replay request is driven low for one clock edge
	task automatic replay();
		rd.replay_request_n <= 1'b0;
		@(posedge aclk);
		rd.replay_request_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== verif/fifo_ports_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module fifo_ports_assertions
	import fifo_ports_pkg::*;
(
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              master_reset_n,
	// Ports
	input wire write_port_t       wr,
	input wire read_port_t        rd,
	input wire axil_req_t         axi_req,
	input wire logic [DATA_W-1:0] q,
	input wire logic              q_oe,
	// Flags
	input wire logic              empty_flag_n,
	input wire logic              output_ready_n,
	input wire logic              full_flag_n,
	input wire logic              input_space_avail_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_oe_follows_sel: assert property (
		$past(aresetn) |-> q_oe == !$past(rd.read_port_select_n))
		else $error("q_oe does not follow read select");
	a_flags_std: assert property (
		!full_flag_n |-> input_space_avail_n && output_ready_n)
		else $error("full flag with ready flags active");
	a_flags_fwft: assert property (
		!input_space_avail_n || !output_ready_n |-> full_flag_n)
		else $error("ready flags with full flag active");
	a_full_holds: assert property (
		!full_flag_n && rd.ren_n && rd.replay_request_n && master_reset_n && !axi_req.wvalid
		&& !$past(axi_req.wvalid) && !$past(axi_req.wvalid, 2) |=> !full_flag_n)
		else $error("full flag cleared without a read");
	a_replay_setup: assert property (
		master_reset_n && $past(master_reset_n) && rd.mark && $past(rd.mark)
		&& !rd.replay_request_n && empty_flag_n |=> !empty_flag_n [*2] ##1 empty_flag_n)
		else $error("replay setup flag sequence wrong");
	a_master_clear: assert property (
		!master_reset_n |=> q == '0 && full_flag_n && output_ready_n)
		else $error("master reset did not clear");
	a_fall_through: assert property (
		!wr.wen_n && !wr.write_port_select_n && master_reset_n && !input_space_avail_n
		&& output_ready_n && empty_flag_n && $past(wr.wen_n) && $past(wr.wen_n, 2)
		|=> output_ready_n [*3] ##1 (!output_ready_n && q == $past(wr.d, 4)))
		else $error("first word did not fall through on third edge");
	a_std_read: assert property (
		!rd.ren_n && !rd.read_port_select_n && empty_flag_n && output_ready_n
		&& input_space_avail_n && master_reset_n |=> q != $past(q))
		else $error("standard read did not load q");
	a_empty_holds: assert property (
		!empty_flag_n && $past(!empty_flag_n) && $past(!empty_flag_n, 2)
		&& wr.write_port_select_n && master_reset_n |=> !empty_flag_n)
		else $error("empty cleared without a write");
endmodule
bind fifo_ports fifo_ports_assertions chk (.aclk, .aresetn, .master_reset_n, .wr, .rd,
	.axi_req, .q, .q_oe, .empty_flag_n, .output_ready_n, .full_flag_n, .input_space_avail_n);
`default_nettype wire

// ==== verif/test_sync_fifo_ports_retransmit.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_sync_fifo_ports_retransmit
	import fifo_ports_pkg::*;
;
	logic              aclk;
	logic              aresetn;
	logic              master_reset_n;
	logic              mode_select_std;
	write_port_t       wr;
	read_port_t        rd;
	logic [DATA_W-1:0] q;
	logic              q_oe;
	logic              empty_flag_n;
	logic              output_ready_n;
	logic              full_flag_n;
	logic              input_space_avail_n;
	axil_req_t         axi_req;
	axil_rsp_t         axi_rsp;
	int                n_mismatch;
	int                comparisons;

	fifo_ctl_model ctl (.aclk, .wr, .rd, .master_reset_n, .mode_select_std);
	fifo_ports dut (.aclk, .aresetn, .master_reset_n, .mode_select_std, .wr, .rd, .q, .q_oe,
		.empty_flag_n, .output_ready_n, .full_flag_n, .input_space_avail_n, .axi_req, .axi_rsp);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ********
	// Helpers
	// ********
	function automatic logic [DATA_W-1:0] word(input int i);
		return 36'hA50000000 + 36'(i);
	endfunction

	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {35'h0, e}, {35'h0, g});
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic tmo(input int t);
		if (t >= 40) begin
			n_mismatch++;
			$display("BAD wait expected done seen timeout");
			print_verdict();
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		for (t = 0; t < 40; t++) begin
			@(posedge aclk);
			if (axi_rsp.awready)
				axi_req.awvalid <= 1'b0;
			if (axi_rsp.wready)
				axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid)
				break;
		end
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
		tmo(t);
		@(posedge aclk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		for (t = 0; t < 40; t++) begin
			@(posedge aclk);
			if (axi_rsp.arready)
				axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid)
				break;
		end
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
		tmo(t);
		@(posedge aclk);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_std();
		ctl.mrst(1'b1);
		chk1("empty after reset", 1'b0, empty_flag_n);
		ctl.put(word(9), 1'b1);
		ctl.get();
		chk("q after refused read", 36'h0, q);
		chk1("empty after deselected write", 1'b0, empty_flag_n);
		for (int i = 0; i < 4; i++)
			ctl.put(word(i), 1'b0);
		chk1("empty with data", 1'b1, empty_flag_n);
		for (int i = 0; i < 4; i++) begin
			ctl.get();
			chk("q standard read", word(i), q);
		end
		chk1("empty drained", 1'b0, empty_flag_n);
		chk1("q driven", 1'b1, q_oe);
		ctl.strobe(1'b0, 1'b1);
		@(posedge aclk);
		chk1("q released", 1'b0, q_oe);
		$display("standard test done");
	endtask

	task automatic t_mark();
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		int          t;
		ctl.mrst(1'b1);
		ctl.strobe(1'b1, 1'b0);
		for (int i = 0; i < 4; i++)
			ctl.put(word(i), 1'b0);
		for (int i = 0; i < 4; i++)
			ctl.get();
		for (n = 0; n < 70 && full_flag_n; n++)
			ctl.put(word(n + 4), 1'b0);
		chk("writes up to mark", 36'h3C, 36'(n));
		ctl.put(word(99), 1'b0);
		axr(STATUS_OFF, d, r);
		chk("status count", 36'h3C03, {4'h0, d});
		ctl.replay();
		#1;
		chk1("empty in setup", 1'b0, empty_flag_n);
		for (t = 0; t < 40 && !empty_flag_n; t++)
			@(posedge aclk);
		tmo(t);
		for (int i = 0; i < 4; i++) begin
			ctl.get();
			chk("q replayed", word(i), q);
		end
		$display("mark test done");
	endtask

	task automatic t_fwft();
		ctl.mrst(1'b0);
		chk1("space after reset", 1'b0, input_space_avail_n);
		ctl.put(word(7), 1'b0);
		@(posedge aclk);
		chk1("no early fall", 1'b1, output_ready_n);
		@(posedge aclk);
		#1;
		chk1("word fallen", 1'b0, output_ready_n);
		chk("q fallen", word(7), q);
		ctl.put(word(8), 1'b0);
		repeat (2) @(posedge aclk);
		ctl.get();
		chk("q next word", word(8), q);
		$display("fall-through test done");
	endtask

	task automatic t_axi();
		logic [31:0] d;
		logic [1:0]  r;
		ctl.mrst(1'b1);
		axw(CTRL_OFF, 32'h2, r);
		chk("hold response", 36'h0, {34'h0, r});
		repeat (2) @(posedge aclk);
		chk1("full under hold", 1'b0, full_flag_n);
		ctl.put(word(1), 1'b0);
		axw(CTRL_OFF, 32'h0, r);
		repeat (2) @(posedge aclk);
		chk1("empty after held write", 1'b0, empty_flag_n);
		axr(8'h08, d, r);
		chk("unmapped response", {34'h0, RESP_DECERR}, {34'h0, r});
		chk("unmapped data", 36'h0, {4'h0, d});
		axr(STATUS_OFF, d, r);
		chk("status mode", 36'h1, {4'h0, d});
		$display("register test done");
	endtask

	initial begin
		aresetn = 1'b0;
		axi_req = '0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_std();
		t_mark();
		t_fwft();
		t_axi();
		print_verdict();
	end
endmodule
`default_nettype wire
